// file: inc/cpf_pkg.sv
// constants and types for the capacitive proximity front-end controller
package cpf_pkg;
  localparam int ADC_W       = 12;          // raw code width
  localparam int PERIOD_W    = 8;           // scan interval setting width
  localparam int TICK_US     = 1000;        // one scan period unit, in us
  localparam int CLK_MHZ     = 20;          // sys_clk rate
  localparam int TICK_CYC    = TICK_US * CLK_MHZ; // cycles per period unit
  localparam int GAIN_W      = 3;           // gain setting width
  localparam int FREQ_W      = 2;           // frequency setting width
  localparam int NSRC        = 5;           // compensation request sources
  localparam logic [ADC_W-1:0] THRESH_RST = 12'h000; // reset threshold
  typedef enum logic [2:0] {
    CPF_IDLE  = 3'b000,
    CPF_REQ   = 3'b001,
    CPF_COMP  = 3'b010,
    CPF_MEAS  = 3'b011,
    CPF_PROC  = 3'b100
  } cpf_state_e;
endpackage

// file: verilog/cpf_ctrl.sv
// sequencer for periodic capacitive proximity sampling
`timescale 1ns/1ps
`default_nettype none
module cpf_ctrl #(
  parameter int TICK_CYCLES = cpf_pkg::TICK_CYC  // shorten in simulation
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // configuration
  input  wire logic [cpf_pkg::PERIOD_W-1:0]  scan_interval_setting,
  input  wire logic                          sense_electrode_select,
  input  wire logic                          guard_electrode_select,
  input  wire logic [cpf_pkg::GAIN_W-1:0]    frontend_gain_setting,
  input  wire logic                          gain_boost_enable,
  input  wire logic [cpf_pkg::FREQ_W-1:0]    frontend_freq_setting,
  input  wire logic                          noise_immunity_enable,
  input  wire logic [cpf_pkg::ADC_W-1:0]     near_threshold,
  // compensation requests other than startup (pulses)
  input  wire logic                          comp_req_host,
  input  wire logic                          comp_req_drift,
  input  wire logic                          comp_req_timer,
  input  wire logic                          comp_req_stuck,
  // shared converter arbitration
  output logic                               adc_req,
  input  wire logic                          adc_gnt,
  // analog front-end controls
  output logic                               afe_start,
  output logic                               afe_comp,
  input  wire logic                          afe_done,
  input  wire logic [cpf_pkg::ADC_W-1:0]     afe_code,
  output logic                               sense_top_layer_en,
  output logic                               sense_ext_pin_en,
  output logic                               guard_bottom_layer_en,
  output logic                               guard_ext_pin_en,
  output logic [cpf_pkg::GAIN_W-1:0]         afe_gain,
  output logic                               afe_boost,
  output logic [cpf_pkg::FREQ_W-1:0]         afe_freq,
  output logic                               afe_high_immunity,
  // results
  output logic [cpf_pkg::ADC_W-1:0]          raw_code,
  output logic                               raw_valid,
  output logic                               near_far_status,
  output logic                               compensation_pending_flag,
  output logic                               prox_busy
);
  import cpf_pkg::*;

  // reset release synchroniser
  logic       rst_s1_reg;                 // first stage
  logic       rst_s2_reg;                 // synchronised active-high-run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic srst_n = rst_s2_reg;

  // async done pulse from the front end passes two flops, then edge detect
  logic       done_s1_reg;
  logic       done_s2_reg;
  logic       done_s3_reg;
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
    end else begin
      done_s1_reg <= afe_done;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
    end
  end
  wire logic done_rise = done_s2_reg & ~done_s3_reg;

  // period unit divider: one-cycle enable per unit
  logic [31:0] div_reg;                    // cycle counter within a unit
  logic        unit_tick;
  assign unit_tick = (div_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) div_reg <= 32'h0;
    else if (unit_tick || scan_interval_setting == '0) div_reg <= 32'h0;
    else div_reg <= div_reg + 32'h1;
  end

  // scan period counter; held at zero when disabled
  logic [PERIOD_W-1:0] per_reg;
  logic                scan_wake;
  assign scan_wake = unit_tick && (per_reg + 8'h1 >= scan_interval_setting);
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) per_reg <= '0;
    else if (scan_interval_setting == '0) per_reg <= '0;
    else if (scan_wake) per_reg <= '0;
    else if (unit_tick) per_reg <= per_reg + 8'h1;
  end

  // enable detect: zero to nonzero period requests compensation
  logic en_reg;
  wire logic en_now = (scan_interval_setting != '0);
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) en_reg <= 1'b0;
    else en_reg <= en_now;
  end

  // five request sources gathered into one vector
  logic [NSRC-1:0] comp_src;
  assign comp_src = {comp_req_stuck, comp_req_timer, comp_req_drift,
                     comp_req_host, en_now & ~en_reg};

  // sequencer state
  cpf_state_e st_reg;
  logic       comp_run_reg;                // compensation in this scan
  logic       comp_done;
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      st_reg       <= CPF_IDLE;
      comp_run_reg <= 1'b0;
    end else begin
      case (st_reg)
        CPF_IDLE: if (scan_wake && en_now) st_reg <= CPF_REQ;
        CPF_REQ: if (adc_gnt) begin         // wait for shared converter
          comp_run_reg <= compensation_pending_flag;
          st_reg <= compensation_pending_flag ? CPF_COMP : CPF_MEAS;
        end
        CPF_COMP: if (done_rise) begin      // environment captured
          comp_run_reg <= 1'b0;
          st_reg <= CPF_MEAS;
        end
        CPF_MEAS: if (done_rise) st_reg <= CPF_PROC;
        CPF_PROC: st_reg <= CPF_IDLE;
        default: st_reg <= CPF_IDLE;
      endcase
    end
  end
  assign comp_done = (st_reg == CPF_COMP) && done_rise;

  // pending flag: set wins over the clear at completion
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) compensation_pending_flag <= 1'b0;
    else if (|comp_src) compensation_pending_flag <= 1'b1;
    else if (comp_done) compensation_pending_flag <= 1'b0;
  end

  // launch strobes toward the front end: one cycle on entry
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      afe_start <= 1'b0;
      afe_comp  <= 1'b0;
    end else begin
      afe_start <= (st_reg == CPF_REQ) && adc_gnt;
      afe_comp  <= (st_reg == CPF_REQ) && adc_gnt && compensation_pending_flag;
    end
  end

  // converter request held across compensation and measurement
  assign adc_req  = (st_reg == CPF_REQ) || (st_reg == CPF_COMP)
                    || (st_reg == CPF_MEAS);
  assign prox_busy = (st_reg != CPF_IDLE);

  // raw capture and near/far decision
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      raw_code        <= '0;
      raw_valid       <= 1'b0;
      near_far_status <= 1'b0;
    end else begin
      raw_valid <= 1'b0;
      if (st_reg == CPF_MEAS && done_rise) begin
        raw_code  <= afe_code;
        raw_valid <= 1'b1;
      end
      if (st_reg == CPF_PROC)
        near_far_status <= (raw_code > near_threshold);
    end
  end

  // electrode routing follows the converter request one cycle later; gain, frequency and immunity settings follow their inputs at all times
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      sense_top_layer_en    <= 1'b0;
      sense_ext_pin_en      <= 1'b0;
      guard_bottom_layer_en <= 1'b0;
      guard_ext_pin_en      <= 1'b0;
      afe_gain              <= '0;
      afe_boost             <= 1'b0;
      afe_freq              <= '0;
      afe_high_immunity     <= 1'b0;
    end else begin
      sense_top_layer_en    <= adc_req && !sense_electrode_select;
      sense_ext_pin_en      <= adc_req && sense_electrode_select;
      guard_bottom_layer_en <= adc_req && !guard_electrode_select;
      guard_ext_pin_en      <= adc_req && guard_electrode_select;
      afe_gain              <= frontend_gain_setting;
      // boost is only honoured with the external sensor pin
      afe_boost             <= gain_boost_enable && sense_electrode_select;
      afe_freq              <= frontend_freq_setting;
      afe_high_immunity     <= noise_immunity_enable;
    end
  end
endmodule // cpf_ctrl
`default_nettype wire

// file: bench/cpf_ctrl_sva.sv
// port assertions for the proximity sequencer
`timescale 1ns/1ps
`default_nettype none
module cpf_ctrl_sva (
  input wire logic sys_clk, rst_n, adc_req, adc_gnt, afe_start, afe_comp,
  input wire logic sense_electrode_select, guard_electrode_select, gain_boost_enable,
  input wire logic sense_top_layer_en, sense_ext_pin_en, guard_ext_pin_en, afe_boost,
  input wire logic raw_valid, near_far_status, comp_req_host, compensation_pending_flag,
  input wire logic [cpf_pkg::PERIOD_W-1:0] scan_interval_setting,
  input wire logic [cpf_pkg::ADC_W-1:0]    raw_code, near_threshold
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // converter must be ours before the front end is launched
  sequence granted_s; adc_req && adc_gnt; endsequence
  sequence enabled_s; $past(scan_interval_setting) == 0 && scan_interval_setting != 0; endsequence
  grant_start_a: assert property (afe_start |-> $past(adc_req && adc_gnt))
    else $error("front end launched without grant");
  comp_start_a: assert property (afe_comp |-> afe_start)
    else $error("compensation without launch");
  zero_idle_a: assert property ((scan_interval_setting == 0) [*8] |-> !adc_req)
    else $error("activity with zero period");
  boost_gate_a: assert property (afe_boost |-> $past(gain_boost_enable && sense_electrode_select))
    else $error("boost without external sensor");
  sense_pick_a: assert property (sense_ext_pin_en |-> !sense_top_layer_en && $past(sense_electrode_select))
    else $error("wrong sensing electrode");
  guard_pick_a: assert property (guard_ext_pin_en |-> $past(guard_electrode_select))
    else $error("wrong guard electrode");
  status_cmp_a: assert property (raw_valid |=> near_far_status == ($past(raw_code) > $past(near_threshold)))
    else $error("status does not follow raw code");
  host_set_a: assert property (comp_req_host |-> ##[1:2] compensation_pending_flag)
    else $error("request did not set pending flag");
  flag_clear_a: assert property ($fell(compensation_pending_flag) |-> adc_req)
    else $error("pending flag cleared outside a scan");
  start_req_a: assert property (enabled_s |=> compensation_pending_flag)
    else $error("enable did not request compensation");
  grant_cov_c: cover property (granted_s ##1 afe_start);
endmodule // cpf_ctrl_sva
bind cpf_ctrl cpf_ctrl_sva u_sva (.*);
`default_nettype wire

// file: bench/cpf_afe_model.sv
// behavioural converter arbiter and sensing front end
`timescale 1ns/1ps
`default_nettype none
module cpf_afe_model (
  input wire logic sys_clk, rst_n, adc_req, afe_start, afe_comp,
  input wire logic [3:0]               slow,
  input wire logic [cpf_pkg::ADC_W-1:0] code_in,
  output logic adc_gnt, afe_done,
  output logic [cpf_pkg::ADC_W-1:0]    afe_code
);
  logic [5:0] cnt_reg; // step within one front-end run
  logic [3:0] wait_reg; // grant delay so far
  logic       comp_reg; // this run opens with compensation
  // grant held until request drops; slow stands for touch traffic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_gnt <= 1'b0; wait_reg <= 4'h0; cnt_reg <= 6'h00; comp_reg <= 1'b0;
    end else begin
      adc_gnt <= adc_req && (adc_gnt || wait_reg >= slow);
      wait_reg <= adc_req ? wait_reg + 4'h1 : 4'h0;
      if (afe_start) comp_reg <= afe_comp;
      cnt_reg <= afe_start ? 6'h01 : (cnt_reg != 6'h00 && cnt_reg != 6'h3f) ? cnt_reg + 6'h01 : cnt_reg;
    end
  end
  // environment capture ends first, then the measurement
  assign afe_done = (comp_reg && cnt_reg inside {[8:13]}) || cnt_reg inside {[24:29]};
  // code is only valid late in the run; inverted junk before that
  assign afe_code = cnt_reg >= 6'd20 ? code_in : ~code_in;
endmodule // cpf_afe_model
`default_nettype wire

// file: bench/capacitive_proximity_frontend_ctrl_bench.sv
// self-checking bench for the proximity sequencer
`timescale 1ns/1ps
`default_nettype none
module capacitive_proximity_frontend_ctrl_bench;
  import cpf_pkg::*;
  logic sys_clk, rst_n, sense_electrode_select, guard_electrode_select, gain_boost_enable;
  logic noise_immunity_enable, comp_req_host, comp_req_drift, comp_req_timer, comp_req_stuck;
  logic adc_req, adc_gnt, afe_start, afe_comp, afe_done, sense_top_layer_en, sense_ext_pin_en;
  logic guard_bottom_layer_en, guard_ext_pin_en, afe_boost, afe_high_immunity, raw_valid;
  logic near_far_status, compensation_pending_flag, prox_busy;
  logic [PERIOD_W-1:0] scan_interval_setting;
  logic [GAIN_W-1:0]   frontend_gain_setting, afe_gain;
  logic [FREQ_W-1:0]   frontend_freq_setting, afe_freq;
  logic [ADC_W-1:0]    near_threshold, afe_code, raw_code, code_in;
  logic [3:0]          slow;
  int error_cnt, comparisons, cycles, comp_seen;
  cpf_ctrl #(.TICK_CYCLES(4)) DUT (.*);
  cpf_afe_model partner (.*);
  initial begin sys_clk = 0; forever #25 sys_clk = ~sys_clk; end
  // cycle ceiling and compensation counter
  always @(posedge sys_clk) begin
    cycles++; comp_seen += afe_comp;
    if (cycles == 5000) begin error_cnt++; wrap_up(); end
  end
  task chk(string n, logic [11:0] e, logic [11:0] g);
    comparisons++;
    if (g !== e) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, g); end
  endtask
  task wrap_up;
    $display("compares %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task step(int n); repeat (n) @(posedge sys_clk); #2; endtask
  // wait one sample and judge pins and result
  task sample;
    int i; i = 0;
    while (raw_valid !== 1'b1 && i < 400) begin step(1); i++; end
    chk("wait", 0, i == 400);
    chk("sns ext", sense_electrode_select, sense_ext_pin_en);
    chk("sns top", !sense_electrode_select, sense_top_layer_en);
    chk("grd ext", guard_electrode_select, guard_ext_pin_en);
    chk("grd bot", !guard_electrode_select, guard_bottom_layer_en);
    chk("boost", gain_boost_enable & sense_electrode_select, afe_boost);
    chk("gain", frontend_gain_setting, afe_gain);
    chk("freq", {noise_immunity_enable, frontend_freq_setting}, {afe_high_immunity, afe_freq});
    chk("raw", code_in, raw_code);
    chk("busy", 1, prox_busy);
    step(1); chk("status", code_in > near_threshold, near_far_status);
    chk("flag", 0, compensation_pending_flag);
    chk("idle", 0, prox_busy);
  endtask
  task t_zero; step(60); chk("idle req", 0, adc_req | compensation_pending_flag | prox_busy); endtask
  task t_startup;
    scan_interval_setting = 8'h02; step(1);
    chk("startup", 1, compensation_pending_flag);
    sample(); chk("comp", 1, comp_seen);
    code_in = 12'h3c1; sample(); chk("comp2", 1, comp_seen);
  endtask
  task t_sources;
    for (int k = 0; k < 4; k++) begin
      {guard_electrode_select, sense_electrode_select} = k[1:0]; slow = 4'(k * 3);
      frontend_gain_setting = 3'(k + 4); code_in = 12'(k * 12'h3ff);
      noise_immunity_enable = k[0]; frontend_freq_setting = 2'(k);
      // raised right as the sequencer returns to idle, so no scan can sneak in unflagged
      {comp_req_stuck, comp_req_timer, comp_req_drift, comp_req_host} = 4'(1 << k);
      step(1); {comp_req_stuck, comp_req_timer, comp_req_drift, comp_req_host} = 4'h0;
      chk("req flag", 1, compensation_pending_flag);
      chk("no comp", k + 1, comp_seen);
      sample(); chk("src comp", k + 2, comp_seen);
    end
  endtask
  initial begin
    rst_n = 0; scan_interval_setting = 0; {sense_electrode_select, guard_electrode_select} = 0;
    {comp_req_host, comp_req_drift, comp_req_timer, comp_req_stuck} = 0; slow = 0;
    gain_boost_enable = 1; noise_immunity_enable = 1; frontend_freq_setting = 2'h3;
    frontend_gain_setting = 3'h1; near_threshold = 12'h800; code_in = 12'h9a5;
    repeat (20) @(posedge sys_clk); #2 rst_n = 1; step(3);
    t_zero(); t_startup(); t_sources();
    wrap_up();
  end
endmodule // capacitive_proximity_frontend_ctrl_bench
`default_nettype wire
